// ===== design/irb_pkg.sv
// irb_pkg: constants for the indexed register block access unit
package irb_pkg;
  // ==========================================================================
  // io ports
  localparam logic [15:0] IRB_PORT_CTRL_LO = 16'h23C0;
  localparam logic [15:0] IRB_PORT_CTRL_HI = 16'h23C1;
  localparam logic [15:0] IRB_PORT_ACC_LO  = 16'h23C2;
  localparam logic [15:0] IRB_PORT_ACC_HI  = 16'h23C3;
  localparam logic [15:0] IRB_PORT_BTE_LO  = 16'h23C4;
  localparam logic [15:0] IRB_PORT_BTE_HI  = 16'h23C5;
  // ==========================================================================
  // index control fields
  localparam int IRB_PTR_LSB   = 0;
  localparam int IRB_IDX_LSB   = 8;
  localparam int IRB_AINC_BIT  = 12;
  localparam int IRB_INV_BIT   = 13;
  localparam int IRB_DATA_W    = 12;
  localparam int IRB_NREG      = 16;
  // ==========================================================================
  // block pointers
  localparam logic [7:0] IRB_BLK_SYS    = 8'h00;
  localparam logic [7:0] IRB_BLK_BTE    = 8'h01;
  localparam logic [7:0] IRB_BLK_CURSOR = 8'h02;
  // ==========================================================================
  // reset values
  localparam logic [7:0]  IRB_RST_PTR  = 8'h00;
  localparam logic [3:0]  IRB_RST_IDX  = 4'h0;
  localparam logic [1:0]  IRB_RST_RSV  = 2'h0;
  localparam logic [11:0] IRB_RST_DATA = 12'h000;
  // implemented registers per block: system 1, engine 16, cursor 9
  localparam logic [15:0] IRB_IMPL_SYS    = 16'h0001;
  localparam logic [15:0] IRB_IMPL_BTE    = 16'hFFFF;
  localparam logic [15:0] IRB_IMPL_CURSOR = 16'h01FF;

  typedef enum logic [1:0] {
    IRB_SEL_SYS    = 2'b00,
    IRB_SEL_BTE    = 2'b01,
    IRB_SEL_CURSOR = 2'b10,
    IRB_SEL_NONE   = 2'b11
  } irb_sel_e;
endpackage

// ===== design/irb_bank.sv
// irb_bank: one block of sixteen twelve-bit indexed registers
module irb_bank (
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_wr,
  input  wire logic [3:0]  i_wr_idx,
  input  wire logic [11:0] i_wr_data,
  input  wire logic [15:0] i_impl,
  input  wire logic [3:0]  i_rd_idx,
  output logic      [11:0] o_rd_data,
  output logic      [15:0] o_regs_flat
);
  // ==========================================================================
  // storage, sixteen twelve-bit words
  logic [11:0] regs      [irb_pkg::IRB_NREG];
  logic [11:0] next_regs [irb_pkg::IRB_NREG];

  always_comb begin
    for (int k = 0; k < irb_pkg::IRB_NREG; k++) begin
      next_regs[k] = regs[k];
    end
    if (i_wr && i_impl[i_wr_idx]) begin
      next_regs[i_wr_idx] = i_wr_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < irb_pkg::IRB_NREG; k++) begin
        regs[k] <= irb_pkg::IRB_RST_DATA;
      end
    end else begin
      for (int k = 0; k < irb_pkg::IRB_NREG; k++) begin
        regs[k] <= next_regs[k];
      end
    end
  end

  // missing registers read as zero
  assign o_rd_data   = i_impl[i_rd_idx] ? regs[i_rd_idx] : irb_pkg::IRB_RST_DATA;
  assign o_regs_flat = i_impl;
endmodule

// ===== design/irb_top.sv
// irb_top: host io port access to the enhanced indexed register blocks
// Contract
// - blocks hold sixteen twelve-bit indexed registers
// - block pointer maps block onto access port
// - access write: index top four, data low twelve
// - repeated writes need no block reselect
// - read word carries index in top bits
// - auto-increment reads ascend and wrap past Fh
// - increment disabled repeats the same register
// - missing registers read zero data
// - control index field shows next read index
// - bit 13 flags unimplemented block, read-only
// - port map 23C0h to 23C5h
// - pointer 00 system, 01 engine, 02 cursor
// - system index 0 is interrupt status
// - status read clears no interrupt
// - bits 15:14 reserved, bit 13 read-only, others read/write
// - unassigned interrupt bits read zero
// - status bit 7 summarises sources 10..7
module irb_top (
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [1:0]  i_io_be,
  input  wire logic [15:0] i_io_wdata,
  input  wire logic [10:1] i_irq_src,
  output logic      [15:0] o_io_rdata,
  output logic             o_io_hit,
  output logic             o_bte_wr,
  output logic             o_bte_rd,
  output logic      [1:0]  o_bte_be,
  output logic      [15:0] o_bte_wdata,
  output logic      [11:0] o_bte_reg [16],
  output logic      [11:0] o_cur_reg [16]
);
  // ==========================================================================
  // port decode: word port at even address, byte lanes from i_io_be
  function automatic logic is_port(input logic [15:0] a, input logic [15:0] lo);
    return (a == lo) || (a == lo + 16'h0001);
  endfunction

  logic sel_ctrl;
  logic sel_acc;
  logic sel_bte;
  assign sel_ctrl = is_port(i_io_addr, irb_pkg::IRB_PORT_CTRL_LO);
  assign sel_acc  = is_port(i_io_addr, irb_pkg::IRB_PORT_ACC_LO);
  assign sel_bte  = is_port(i_io_addr, irb_pkg::IRB_PORT_BTE_LO);
  assign o_io_hit = sel_ctrl | sel_acc | sel_bte;

  // engine data port is passed out to the engine itself
  assign o_bte_wr    = i_io_wr & sel_bte;
  assign o_bte_rd    = i_io_rd & sel_bte;
  assign o_bte_be    = i_io_be;
  assign o_bte_wdata = i_io_wdata;

  // ==========================================================================
  // index control register
  logic [7:0] blk_ptr;
  logic [3:0] rd_idx;
  logic       ainc_dis;
  logic [1:0] rsv;
  logic [7:0] next_blk_ptr;
  logic [3:0] next_rd_idx;
  logic       next_ainc_dis;
  logic [1:0] next_rsv;
  irb_pkg::irb_sel_e sel;

  always_comb begin
    case (blk_ptr)
      irb_pkg::IRB_BLK_SYS:    sel = irb_pkg::IRB_SEL_SYS;
      irb_pkg::IRB_BLK_BTE:    sel = irb_pkg::IRB_SEL_BTE;
      irb_pkg::IRB_BLK_CURSOR: sel = irb_pkg::IRB_SEL_CURSOR;
      default:                 sel = irb_pkg::IRB_SEL_NONE;
    endcase
  end

  logic invalid;
  assign invalid = (sel == irb_pkg::IRB_SEL_NONE);

  logic acc_rd;
  logic acc_wr;
  assign acc_rd = i_io_rd & sel_acc & i_io_be[1];
  assign acc_wr = i_io_wr & sel_acc & (&i_io_be);

  always_comb begin
    next_blk_ptr  = blk_ptr;
    next_rd_idx   = rd_idx;
    next_ainc_dis = ainc_dis;
    next_rsv      = rsv;
    if (i_io_wr && sel_ctrl) begin
      if (i_io_be[0]) begin
        next_blk_ptr = i_io_wdata[7:0];
      end
      if (i_io_be[1]) begin
        // bit 13 is computed, never stored
        next_rd_idx   = i_io_wdata[11:8];
        next_ainc_dis = i_io_wdata[irb_pkg::IRB_AINC_BIT];
        next_rsv      = i_io_wdata[15:14];
      end
    end else if (acc_rd && !ainc_dis) begin
      next_rd_idx = rd_idx + 4'h1; // wraps Fh to 0
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      blk_ptr  <= irb_pkg::IRB_RST_PTR;
      rd_idx   <= irb_pkg::IRB_RST_IDX;
      ainc_dis <= 1'b0;
      rsv      <= irb_pkg::IRB_RST_RSV;
    end else begin
      blk_ptr  <= next_blk_ptr;
      rd_idx   <= next_rd_idx;
      ainc_dis <= next_ainc_dis;
      rsv      <= next_rsv;
    end
  end

  // ==========================================================================
  // banks; writes stay in the selected block
  logic        wr_bte;
  logic        wr_cur;
  logic [11:0] bte_data;
  logic [11:0] cur_data;
  assign wr_bte = acc_wr && (sel == irb_pkg::IRB_SEL_BTE);
  assign wr_cur = acc_wr && (sel == irb_pkg::IRB_SEL_CURSOR);

  logic [11:0] bte_store [16];
  logic [11:0] cur_store [16];

  irb_bank u_bte (
    .i_sys_clk   (i_sys_clk),
    .i_nrst      (i_nrst),
    .i_wr        (wr_bte),
    .i_wr_idx    (i_io_wdata[15:12]),
    .i_wr_data   (i_io_wdata[11:0]),
    .i_impl      (irb_pkg::IRB_IMPL_BTE),
    .i_rd_idx    (rd_idx),
    .o_rd_data   (bte_data),
    .o_regs_flat ()
  );

  irb_bank u_cur (
    .i_sys_clk   (i_sys_clk),
    .i_nrst      (i_nrst),
    .i_wr        (wr_cur),
    .i_wr_idx    (i_io_wdata[15:12]),
    .i_wr_data   (i_io_wdata[11:0]),
    .i_impl      (irb_pkg::IRB_IMPL_CURSOR),
    .i_rd_idx    (rd_idx),
    .o_rd_data   (cur_data),
    .o_regs_flat ()
  );

  // contents exported by a shadow of each write; banks keep the read path
  logic [11:0] next_bte_store [16];
  logic [11:0] next_cur_store [16];
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      next_bte_store[k] = bte_store[k];
      next_cur_store[k] = cur_store[k];
    end
    if (wr_bte) begin
      next_bte_store[i_io_wdata[15:12]] = i_io_wdata[11:0];
    end
    if (wr_cur && irb_pkg::IRB_IMPL_CURSOR[i_io_wdata[15:12]]) begin
      next_cur_store[i_io_wdata[15:12]] = i_io_wdata[11:0];
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < 16; k++) begin
        bte_store[k] <= irb_pkg::IRB_RST_DATA;
        cur_store[k] <= irb_pkg::IRB_RST_DATA;
      end
    end else begin
      for (int k = 0; k < 16; k++) begin
        bte_store[k] <= next_bte_store[k];
        cur_store[k] <= next_cur_store[k];
      end
    end
  end
  assign o_bte_reg = bte_store;
  assign o_cur_reg = cur_store;

  // ==========================================================================
  // interrupt status, live view of sources, reading clears nothing
  logic [11:0] irq_status;
  always_comb begin
    irq_status        = 12'h000;
    irq_status[11:8]  = i_irq_src[10:7];
    irq_status[7]     = |i_irq_src[10:7];
    irq_status[6:1]   = i_irq_src[6:1];
    irq_status[0]     = |i_irq_src;
  end

  logic [11:0] sys_data;
  assign sys_data = (rd_idx == 4'h0) ? irq_status : irb_pkg::IRB_RST_DATA;

  // ==========================================================================
  // read data, registered
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  logic [11:0] blk_data;

  always_comb begin
    case (sel)
      irb_pkg::IRB_SEL_SYS:    blk_data = sys_data;
      irb_pkg::IRB_SEL_BTE:    blk_data = bte_data;
      irb_pkg::IRB_SEL_CURSOR: blk_data = cur_data;
      default:                 blk_data = irb_pkg::IRB_RST_DATA;
    endcase
  end

  always_comb begin
    next_rdata = 16'h0000;
    if (i_io_rd && sel_ctrl) begin
      next_rdata = {rsv, invalid, ainc_dis, rd_idx, blk_ptr};
    end else if (i_io_rd && sel_acc) begin
      next_rdata = {rd_idx, blk_data};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end
  assign o_io_rdata = rdata;

  // ==========================================================================
  // checks
  a_idx_advance: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (acc_rd && !ainc_dis && !(i_io_wr && sel_ctrl)) |=> (rd_idx == $past(rd_idx) + 4'h1))
    else $error("index did not advance");
  a_idx_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (acc_rd && ainc_dis && !(i_io_wr && sel_ctrl)) |=> $stable(rd_idx))
    else $error("index moved while increment disabled");
  a_rd_index_tag: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_io_rd && sel_acc) |=> (o_io_rdata[15:12] == $past(rd_idx)))
    else $error("read word lacks index");
  a_invalid_flag: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_io_rd && sel_ctrl) |=> (o_io_rdata[13] == ($past(blk_ptr) > 8'h02)))
    else $error("invalid block flag wrong");
  a_nonexist_zero: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_io_rd && sel_acc && invalid) |=> (o_io_rdata[11:0] == 12'h000))
    else $error("missing block data not zero");
  a_summary_bit: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_io_rd && sel_acc && sel == irb_pkg::IRB_SEL_SYS && rd_idx == 4'h0)
    |=> (o_io_rdata[7] == |o_io_rdata[11:8]))
    else $error("summary bit wrong");
  a_ptr_load: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_io_wr && sel_ctrl && i_io_be[0]) |=> (blk_ptr == $past(i_io_wdata[7:0])))
    else $error("pointer not loaded");
  a_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (acc_rd && !ainc_dis && rd_idx == 4'hF && !(i_io_wr && sel_ctrl)) |=> (rd_idx == 4'h0))
    else $error("index did not wrap");

  // ==========================================================================
  // sequences; status is a live view so repeated reads agree without a clear
  sequence s_status_read;
    i_io_rd && sel_acc && (sel == irb_pkg::IRB_SEL_SYS) && (rd_idx == 4'h0);
  endsequence
  sequence s_status_word;
    (o_io_rdata[11:8] == $past(i_irq_src[10:7])) && (o_io_rdata[6:1] == $past(i_irq_src[6:1]));
  endsequence
  sequence s_cur_write;
    wr_cur && irb_pkg::IRB_IMPL_CURSOR[i_io_wdata[15:12]];
  endsequence
  sequence s_ctrl_hi_write;
    i_io_wr && sel_ctrl && i_io_be[1];
  endsequence
  a_status_live: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    s_status_read |=> s_status_word)
    else $error("status word not live");
  a_rd_idle: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (!i_io_rd) |=> (o_io_rdata == 16'h0000))
    else $error("read data not idle");
  a_cur_write: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    s_cur_write |=> (o_cur_reg[$past(i_io_wdata[15:12])] == $past(i_io_wdata[11:0])))
    else $error("cursor write lost");
  a_cur_unimpl: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_io_rd && sel_acc && (sel == irb_pkg::IRB_SEL_CURSOR) && (rd_idx > 4'h8))
    |=> (o_io_rdata[11:0] == 12'h000))
    else $error("missing cursor register not zero");
  a_idx_load: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    s_ctrl_hi_write
    |=> (rd_idx == $past(i_io_wdata[11:8])) && (ainc_dis == $past(i_io_wdata[12])))
    else $error("index field not loaded");
  // a host write of the flag never masks a valid pointer
  a_ptr_valid: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_io_wr && sel_ctrl && i_io_be[0] && i_io_wdata[13] && (i_io_wdata[7:0] <= irb_pkg::IRB_BLK_CURSOR))
    |=> !invalid)
    else $error("flag write not ignored");
endmodule

// ===== tb/irb_host.sv
// irb_host: host processor model issuing io port cycles to the unit
module irb_host (
  input  wire logic        i_sys_clk,
  input  wire logic [15:0] i_rdata,
  output logic      [15:0] o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [1:0]  o_be,
  output logic      [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // idle bus
  initial begin
    o_addr  = 16'h0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_be    = 2'b11;
    o_wdata = 16'h0000;
  end
  // ==========================================================================
  // one-cycle strobes; released lines flip so stale data never looks valid
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    wr_be(a, d, 2'b11);
  endtask
  task automatic wr_be(input logic [15:0] a, input logic [15:0] d, input logic [1:0] b);
    @(posedge i_sys_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_be    <= b;
    o_wr    <= 1'b1;
    @(posedge i_sys_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
    o_addr  <= ~a;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_be   <= 2'b11;
    o_rd   <= 1'b1;
    @(posedge i_sys_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(negedge i_sys_clk);
    d = i_rdata;
  endtask
endmodule

// ===== tb/irb_top_tb.sv
// irb_top_tb: self-checking bench for the indexed register block unit
module irb_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // wiring
  logic        i_sys_clk;
  logic        i_nrst;
  logic [10:1] irq;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        wr;
  logic        rd;
  logic [1:0]  be;
  logic [11:0] bte_reg [16];
  logic [11:0] cur_reg [16];
  logic [11:0] eng     [16];
  logic [11:0] cexp    [16];
  logic [15:0] got;
  logic [3:0]  st;
  logic [7:0]  p;
  logic        hit;
  logic        bwr;
  logic        brd;
  logic [1:0]  bbe;
  logic [15:0] bwdata;
  logic [15:0] bte_seen;
  logic [1:0]  bbe_seen;
  logic [15:0] d;
  int          strobe_n    = 0;
  int          hit_n       = 0;
  int          bwr_n       = 0;
  int          brd_n       = 0;
  int          miscompares = 0;
  int          check_count = 0;
  int          seed        = 20;

  irb_top u_irb_top (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_io_addr(addr), .i_io_wr(wr),
    .i_io_rd(rd), .i_io_be(be), .i_io_wdata(wdata), .i_irq_src(irq), .o_io_rdata(rdata),
    .o_io_hit(hit), .o_bte_wr(bwr), .o_bte_rd(brd), .o_bte_be(bbe), .o_bte_wdata(bwdata),
    .o_bte_reg(bte_reg), .o_cur_reg(cur_reg));
  irb_host u_irb_host (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_be(be), .o_wdata(wdata));
  // ==========================================================================
  // helpers
  function automatic logic [15:0] irq_word(input logic [10:1] s);
    return {4'h0, s[10:7], |s[10:7], s[6:1], |s};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] a);
    check_count++;
    if (a !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, a);
      miscompares++;
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // clock and watchdog
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #(4 * 5000);
    miscompares++;
    complete_run();
  end
  // ==========================================================================
  // strobe monitor for the decode and engine pass-through outputs
  always @(posedge i_sys_clk) begin
    if (wr || rd) begin
      strobe_n <= strobe_n + 1;
      hit_n    <= hit_n + int'(hit);
    end
    if (bwr) begin
      bte_seen <= bwdata;
      bbe_seen <= bbe;
    end
    bwr_n <= bwr_n + int'(bwr);
    brd_n <= brd_n + int'(brd);
  end
  // ==========================================================================
  // scenarios
  initial begin
    i_nrst = 1'b0;
    irq    = 10'h000;
    repeat (20) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    u_irb_host.rd(irb_pkg::IRB_PORT_CTRL_LO, got);
    chk("ctrl_reset", 16'h0000, got);
    // engine block filled under a single select
    u_irb_host.wr(irb_pkg::IRB_PORT_CTRL_LO, 16'h0001);
    for (int i = 0; i < 16; i++) begin
      eng[i] = 12'($random(seed));
      u_irb_host.wr(irb_pkg::IRB_PORT_ACC_LO, {4'(i), eng[i]});
    end
    // last write lands on this edge; look once it has settled
    @(negedge i_sys_clk);
    for (int i = 0; i < 16; i++) begin
      chk("bte_reg", {4'h0, eng[i]}, {4'h0, bte_reg[i]});
    end
    // random start, reads run past Fh and wrap
    st = 4'($random(seed));
    u_irb_host.wr(irb_pkg::IRB_PORT_CTRL_LO, {4'h0, st, 8'h01});
    for (int i = 0; i < 18; i++) begin
      u_irb_host.rd(irb_pkg::IRB_PORT_ACC_HI, got);
      chk("acc_rd", {st + 4'(i), eng[st + 4'(i)]}, got);
    end
    u_irb_host.rd(irb_pkg::IRB_PORT_CTRL_LO, got);
    chk("ctrl_idx", {4'h0, st + 4'h2, 8'h01}, got);
    // increment disabled holds the index
    u_irb_host.wr(irb_pkg::IRB_PORT_CTRL_LO, {4'h1, st, 8'h01});
    for (int i = 0; i < 3; i++) begin
      u_irb_host.rd(irb_pkg::IRB_PORT_ACC_LO, got);
      chk("acc_hold", {st, eng[st]}, got);
    end
    // cursor block: only indices 0..8 exist
    u_irb_host.wr(irb_pkg::IRB_PORT_CTRL_LO, {8'h00, irb_pkg::IRB_BLK_CURSOR});
    for (int i = 0; i < 16; i++) begin
      eng[i]  = 12'($random(seed));
      cexp[i] = (i < 9) ? eng[i] : 12'h000;
      u_irb_host.wr(irb_pkg::IRB_PORT_ACC_LO, {4'(i), eng[i]});
    end
    for (int i = 0; i < 16; i++) begin
      u_irb_host.rd(irb_pkg::IRB_PORT_ACC_LO, got);
      chk("cur_rd", {4'(i), cexp[i]}, got);
      chk("cur_reg", {4'h0, cexp[i]}, {4'h0, cur_reg[i]});
    end
    // missing blocks: flag set, own write to the flag dropped
    for (int j = 0; j < 3; j++) begin
      p = (j == 0) ? 8'h03 : (j == 1) ? 8'hFF : 8'h03 + 8'($random(seed) & 8'h7F);
      u_irb_host.wr(irb_pkg::IRB_PORT_CTRL_LO, {4'h8, 4'h5, p});
      u_irb_host.rd(irb_pkg::IRB_PORT_CTRL_HI, got);
      chk("ctrl_inv", {4'hA, 4'h5, p}, got);
      u_irb_host.rd(irb_pkg::IRB_PORT_ACC_LO, got);
      chk("inv_rd", 16'h5000, got);
    end
    u_irb_host.wr(irb_pkg::IRB_PORT_CTRL_LO, 16'h2001);
    u_irb_host.rd(irb_pkg::IRB_PORT_CTRL_LO, got);
    chk("ctrl_ro", 16'h0001, got);
    // interrupt status, read twice; reading clears nothing
    for (int j = 0; j < 4; j++) begin
      @(posedge i_sys_clk);
      irq <= (j == 0) ? 10'h000 : (j == 1) ? 10'h200 : (j == 2) ? 10'h001 : 10'($random(seed));
      u_irb_host.wr(irb_pkg::IRB_PORT_CTRL_LO, 16'h1000);
      repeat (2) begin
        u_irb_host.rd(irb_pkg::IRB_PORT_ACC_LO, got);
        chk("irq_stat", irq_word(irq), got);
      end
    end
    u_irb_host.rd(irb_pkg::IRB_PORT_CTRL_HI, got);
    chk("ctrl_alias", 16'h1000, got);
    // byte lanes: each half of the control word loads alone
    u_irb_host.wr_be(irb_pkg::IRB_PORT_CTRL_LO, 16'hF302, 2'b01);
    u_irb_host.rd(irb_pkg::IRB_PORT_CTRL_LO, got);
    chk("ctrl_lo_lane", 16'h1002, got);
    u_irb_host.wr_be(irb_pkg::IRB_PORT_CTRL_HI, 16'h4A55, 2'b10);
    u_irb_host.rd(irb_pkg::IRB_PORT_CTRL_LO, got);
    chk("ctrl_hi_lane", 16'h4A02, got);
    // half-word access write is dropped
    u_irb_host.wr_be(irb_pkg::IRB_PORT_ACC_LO, {4'h3, ~cexp[3]}, 2'b01);
    @(negedge i_sys_clk);
    chk("acc_lane", {4'h0, cexp[3]}, {4'h0, cur_reg[3]});
    // reserved port is not decoded and changes nothing
    u_irb_host.wr(16'h23C6, 16'hFFFF);
    u_irb_host.rd(irb_pkg::IRB_PORT_CTRL_LO, got);
    chk("rsv_port", 16'h4A02, got);
    // engine data port passes straight through
    d = 16'($random(seed));
    u_irb_host.wr(irb_pkg::IRB_PORT_BTE_HI, d);
    u_irb_host.rd(irb_pkg::IRB_PORT_BTE_LO, got);
    chk("bte_rdata", 16'h0000, got);
    chk("bte_wdata", d, bte_seen);
    chk("bte_be", 16'h0003, {14'h0000, bbe_seen});
    chk("bte_strb", 16'h0101, {8'(bwr_n), 8'(brd_n)});
    chk("io_hit", 16'(strobe_n - 1), 16'(hit_n));
    complete_run();
  end
endmodule
